/* pacm_consts.svh */
`ifndef PACM_CONSTS_SVH
`define PACM_CONSTS_SVH

`define PACM_ROWS        64
`define PACM_COLS        64
`define PACM_GRP_COLS    8
`define PACM_PIX_BYTES   512
`define PACM_ROUTE_BYTES 32
`define PACM_MEM_BYTES   544
`define PACM_IDX_W       10
`define PACM_ADDR_W      16
`define PACM_PIX_FIRST   16'h0000
`define PACM_PIX_LAST    16'h01FF
`define PACM_ROUTE_FIRST 16'h0400
`define PACM_ROUTE_LAST  16'h041F
`define PACM_CODE_A_POS  4'h0
`define PACM_CODE_A_NEG  4'h1
`define PACM_CODE_B_POS  4'h2
`define PACM_CODE_B_NEG  4'h3
`define PACM_CODE_Z_POS  4'h4
`define PACM_CODE_Z_NEG  4'h5
`define PACM_READ_ZERO   8'h00

`endif

/* pacm_pkg.sv */
`include "pacm_consts.svh"

package pacm_pkg;

  // one-hot selection of an aggregate output, all zero means shunted
  typedef struct packed {
    logic a_pos;
    logic a_neg;
    logic b_pos;
    logic b_neg;
    logic z_pos;
    logic z_neg;
  } pacm_route_t;

  typedef struct packed {
    logic                      wr;
    logic                      rd;
    logic [`PACM_ADDR_W-1:0]   addr;
    logic [7:0]                wdata;
  } pacm_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } pacm_resp_t;

  typedef struct packed {
    logic [`PACM_MEM_BYTES-1:0][7:0] bytes;
  } pacm_mem_state_t;

  typedef struct packed {
    logic                                    valid;
    logic [`PACM_ROWS-1:0][`PACM_COLS-1:0]   pix;
    pacm_route_t [`PACM_COLS-1:0]            route;
  } pacm_top_state_t;

endpackage : pacm_pkg

/* pacm_byte_mem.sv */
`timescale 1ns/1ps
`include "pacm_consts.svh"

module pacm_byte_mem
  import pacm_pkg::*;
(
  input  wire logic                                  mclk_in,
  input  wire logic                                  rstn_in,
  input  wire logic                                  wr_en_in,
  input  wire logic [`PACM_IDX_W-1:0]                wr_idx_in,
  input  wire logic [7:0]                            wr_data_in,
  input  wire logic                                  rd_en_in,
  input  wire logic                                  rd_hit_in,
  input  wire logic [`PACM_IDX_W-1:0]                rd_idx_in,
  output logic      [7:0]                            rd_data_out,
  output logic      [`PACM_MEM_BYTES-1:0][7:0]       contents_out
);

  pacm_mem_state_t mem_q;
  pacm_mem_state_t mem_d;
  logic [7:0]      rdata_q;

  always_comb
  begin
    mem_d = mem_q;
    if (wr_en_in)
    begin
      mem_d.bytes[wr_idx_in] = wr_data_in;
    end
  end

  // no reset: contents are random until software loads them
  always_ff @(posedge mclk_in)
  begin
    mem_q <= mem_d;
  end

  // read sees the contents before a same-cycle write
  always_ff @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      rdata_q <= `PACM_READ_ZERO;
    end
    else if (rd_en_in)
    begin
      rdata_q <= rd_hit_in ? mem_q.bytes[rd_idx_in] : `PACM_READ_ZERO;
    end
  end

  assign rd_data_out  = rdata_q;
  assign contents_out = mem_q.bytes;

endmodule : pacm_byte_mem

/* pacm_top.sv */
// Functional notes
// - configuration covers 4096 pixels, 64 rows by 64 columns.
// - enabled pixel feeds its column's output; disabled pixel is shunted.
// - pixel enable bits are 512 bytes at 0x000 to 0x1FF.
// - column route codes are 32 bytes at 0x400 to 0x41F.
// - both stores are volatile and lose contents at power cycle.
// - row 00 is the top row, row 63 the bottom.
// - eight groups of 8 columns, numbered 0,4,1,5,2,6,3,7 left to right.
// - enable byte address is row number then group number, upper bits zero.
// - enable byte LSB is leftmost pixel, MSB rightmost.
// - route byte covers two columns; low nibble left, high nibble right.
// - route bytes step left to right with rising address.
// - codes 0..5 select A+,A-,B+,B-,Z+,Z-; others shunt to ground.
// - both stores leave reset with unspecified contents.
`timescale 1ns/1ps
`include "pacm_consts.svh"

module pacm_top
  import pacm_pkg::*;
(
  input  wire logic                                  mclk_in,
  input  wire logic                                  rstn_in,
  input  wire pacm_req_t                             reg_req_in,
  output pacm_resp_t                                 reg_resp_out,
  output logic      [`PACM_ROWS-1:0][`PACM_COLS-1:0] pixel_enable_bits_out,
  output pacm_route_t [`PACM_COLS-1:0]               column_route_select_out
);

  pacm_top_state_t                  st_q;
  pacm_top_state_t                  st_d;
  logic [`PACM_MEM_BYTES-1:0][7:0]  mem_bytes;
  logic [7:0]                       mem_rdata;
  logic                             req_pix;
  logic                             req_route;
  logic [`PACM_IDX_W-1:0]           req_idx;

  function automatic logic is_pix(input logic [`PACM_ADDR_W-1:0] addr);
    is_pix = (addr >= `PACM_PIX_FIRST) && (addr <= `PACM_PIX_LAST);
  endfunction : is_pix

  function automatic logic is_route(input logic [`PACM_ADDR_W-1:0] addr);
    is_route = (addr >= `PACM_ROUTE_FIRST) && (addr <= `PACM_ROUTE_LAST);
  endfunction : is_route

  // storage index: pixel bytes first, route bytes packed right after
  function automatic logic [`PACM_IDX_W-1:0] mem_index(input logic [`PACM_ADDR_W-1:0] addr);
    if (is_pix(addr))
    begin
      mem_index = addr[`PACM_IDX_W-1:0];
    end
    else
    begin
      mem_index = `PACM_IDX_W'(`PACM_PIX_BYTES) + `PACM_IDX_W'(addr[4:0]);
    end
  endfunction : mem_index

  // group number from left-to-right position: 0,4,1,5,2,6,3,7
  function automatic logic [2:0] grp_of_pos(input logic [2:0] pos);
    grp_of_pos = {pos[0], pos[2:1]};
  endfunction : grp_of_pos

  function automatic logic [2:0] pos_of_grp(input logic [2:0] grp);
    pos_of_grp = {grp[1:0], grp[2]};
  endfunction : pos_of_grp

  function automatic pacm_route_t decode_route(input logic [3:0] code);
    pacm_route_t r;
    r = '0;
    case (code)
      `PACM_CODE_A_POS: r.a_pos = 1'b1;
      `PACM_CODE_A_NEG: r.a_neg = 1'b1;
      `PACM_CODE_B_POS: r.b_pos = 1'b1;
      `PACM_CODE_B_NEG: r.b_neg = 1'b1;
      `PACM_CODE_Z_POS: r.z_pos = 1'b1;
      `PACM_CODE_Z_NEG: r.z_neg = 1'b1;
      default:          r = '0;
    endcase
    decode_route = r;
  endfunction : decode_route

  assign req_pix   = is_pix(reg_req_in.addr);
  assign req_route = is_route(reg_req_in.addr);
  assign req_idx   = mem_index(reg_req_in.addr);

  // writes to unmapped addresses are dropped
  pacm_byte_mem u_mem (
    .mclk_in      (mclk_in),
    .rstn_in      (rstn_in),
    .wr_en_in     (reg_req_in.wr && (req_pix || req_route)),
    .wr_idx_in    (req_idx),
    .wr_data_in   (reg_req_in.wdata),
    .rd_en_in     (reg_req_in.rd),
    .rd_hit_in    (req_pix || req_route),
    .rd_idx_in    (req_idx),
    .rd_data_out  (mem_rdata),
    .contents_out (mem_bytes)
  );

  always_comb
  begin
    st_d       = st_q;
    st_d.valid = reg_req_in.rd;
    // whole array refreshed every cycle, so outputs lag the store by one edge
    for (int r = 0; r < `PACM_ROWS; r++)
    begin
      for (int c = 0; c < `PACM_COLS; c++)
      begin
        st_d.pix[r][c] = mem_bytes[{1'b0, 6'(r), grp_of_pos(3'(c / `PACM_GRP_COLS))}]
                                  [3'(c % `PACM_GRP_COLS)];
      end
    end
    for (int c = 0; c < `PACM_COLS; c++)
    begin
      if (c % 2 == 0)
      begin
        st_d.route[c] = decode_route(
          mem_bytes[`PACM_IDX_W'(`PACM_PIX_BYTES + c / 2)][3:0]);
      end
      else
      begin
        st_d.route[c] = decode_route(
          mem_bytes[`PACM_IDX_W'(`PACM_PIX_BYTES + c / 2)][7:4]);
      end
    end
  end

  // reset value is all shunted, a safe state only until the first edge after reset copies the store
  always_ff @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign reg_resp_out            = '{valid: st_q.valid, data: mem_rdata};
  assign pixel_enable_bits_out   = st_q.pix;
  assign column_route_select_out = st_q.route;

  function automatic logic [7:0] pix_byte(
    input logic [`PACM_ROWS-1:0][`PACM_COLS-1:0] pix,
    input logic [`PACM_ADDR_W-1:0]               addr);
    logic [2:0] pos;
    logic [7:0] b;
    pos = pos_of_grp(addr[2:0]);
    b   = '0;
    for (int i = 0; i < `PACM_GRP_COLS; i++)
    begin
      b[i] = pix[addr[8:3]][{pos, 3'(i)}];
    end
    pix_byte = b;
  endfunction : pix_byte

  function automatic logic [11:0] route_pair(
    input pacm_route_t [`PACM_COLS-1:0] route,
    input logic [`PACM_ADDR_W-1:0]      addr);
    route_pair = {route[{addr[4:0], 1'b1}], route[{addr[4:0], 1'b0}]};
  endfunction : route_pair

  function automatic logic routes_legal(input pacm_route_t [`PACM_COLS-1:0] route);
    logic ok;
    ok = 1'b1;
    for (int c = 0; c < `PACM_COLS; c++)
    begin
      ok = ok && $onehot0(route[c]);
    end
    routes_legal = ok;
  endfunction : routes_legal

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rstn_in);

  a_pix_write_seen: assert property (
    (reg_req_in.wr && req_pix) ##1 !reg_req_in.wr
    |-> ##1 pix_byte(pixel_enable_bits_out, $past(reg_req_in.addr, 2))
            == $past(reg_req_in.wdata, 2))
    else $error("pixel byte write not reflected two cycles later");

  a_route_write_seen: assert property (
    (reg_req_in.wr && req_route) ##1 !reg_req_in.wr
    |-> ##1 route_pair(column_route_select_out, $past(reg_req_in.addr, 2))
            == {decode_route($past(reg_req_in.wdata[7:4], 2)),
                decode_route($past(reg_req_in.wdata[3:0], 2))})
    else $error("route byte write not reflected two cycles later");

  a_pix_read_back: assert property (
    (reg_req_in.rd && req_pix)
    |=> reg_resp_out.valid
        && reg_resp_out.data == pix_byte(pixel_enable_bits_out, $past(reg_req_in.addr)))
    else $error("pixel byte read disagrees with stored value");

  a_route_read_back: assert property (
    (reg_req_in.rd && req_route)
    |=> {decode_route(reg_resp_out.data[7:4]), decode_route(reg_resp_out.data[3:0])}
        == route_pair(column_route_select_out, $past(reg_req_in.addr)))
    else $error("route byte read disagrees with decoded selection");

  a_unmapped_zero: assert property (
    (reg_req_in.rd && !req_pix && !req_route)
    |=> reg_resp_out.valid && reg_resp_out.data == `PACM_READ_ZERO)
    else $error("unmapped read did not return zero");

  a_resp_only_read: assert property (
    !reg_req_in.rd |=> !reg_resp_out.valid)
    else $error("response valid without a read");

  a_route_onehot: assert property (
    routes_legal(column_route_select_out))
    else $error("a column selects more than one output");

  a_shunt_code: assert property (
    (reg_req_in.wr && req_route && reg_req_in.wdata[3:0] > `PACM_CODE_Z_NEG)
    ##1 !reg_req_in.wr
    |-> ##1 column_route_select_out[{$past(reg_req_in.addr[4:0], 2), 1'b0}] == '0)
    else $error("illegal code did not shunt the left column");

  // outputs copy the store one edge after reset; that edge is no write
  a_hold_no_write: assert property (
    rstn_in && !reg_req_in.wr ##1 !reg_req_in.wr
    |=> $stable(pixel_enable_bits_out) && $stable(column_route_select_out))
    else $error("selections changed without a write");

  a_read_valid: assert property (
    reg_req_in.rd |=> reg_resp_out.valid)
    else $error("read not answered in the next cycle");

  // read data is a register, so it stands until the next read
  a_data_hold: assert property (
    !reg_req_in.rd |=> $stable(reg_resp_out.data))
    else $error("read data changed without a read");

  // two edges: the store takes the write, then the outputs copy the store
  a_unmapped_drop: assert property (
    rstn_in && reg_req_in.wr && !req_pix && !req_route
    |-> ##2 $stable(pixel_enable_bits_out) && $stable(column_route_select_out))
    else $error("write outside the map changed a selection");

  a_shunt_code_hi: assert property (
    (reg_req_in.wr && req_route && reg_req_in.wdata[7:4] > `PACM_CODE_Z_NEG)
    ##1 !reg_req_in.wr
    |-> ##1 column_route_select_out[{$past(reg_req_in.addr[4:0], 2), 1'b1}] == '0)
    else $error("illegal code did not shunt the right column");

  // safe state on the cycle reset is released, before the outputs copy the store
  a_reset_shunt: assert property (
    $rose(rstn_in)
    |-> pixel_enable_bits_out == '0 && column_route_select_out == '0 && !reg_resp_out.valid)
    else $error("outputs not shunted on leaving reset");

  // end groups checked per row, without the group reorder helpers
  for (genvar gr = 0; gr < `PACM_ROWS; gr++)
  begin : g_row_chk
    a_row_left_grp: assert property (
      (reg_req_in.wr && reg_req_in.addr == 16'(gr * 8)) ##1 !reg_req_in.wr
      |-> ##1 pixel_enable_bits_out[gr][7:0] == $past(reg_req_in.wdata, 2))
      else $error("leftmost group of a row not loaded from its byte");

    a_row_right_grp: assert property (
      (reg_req_in.wr && reg_req_in.addr == 16'(gr * 8 + 7)) ##1 !reg_req_in.wr
      |-> ##1 pixel_enable_bits_out[gr][63:56] == $past(reg_req_in.wdata, 2))
      else $error("rightmost group of a row not loaded from its byte");
  end : g_row_chk

  // group order written out as a table, independent of the bit swaps above
  localparam logic [2:0] GRP_AT_POS [8] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};

  for (genvar gp = 0; gp < `PACM_GRP_COLS; gp++)
  begin : g_grp_chk
    a_grp_position: assert property (
      (reg_req_in.wr && req_pix && reg_req_in.addr[2:0] == GRP_AT_POS[gp])
      ##1 !reg_req_in.wr
      |-> ##1 pixel_enable_bits_out[$past(reg_req_in.addr[8:3], 2)][gp * 8 +: 8]
              == $past(reg_req_in.wdata, 2))
      else $error("pixel byte landed in the wrong column group");
  end : g_grp_chk

  // two checks per column, so a misplaced nibble shows up by column
  for (genvar gc = 0; gc < `PACM_COLS; gc++)
  begin : g_col_chk
    a_col_code_lit: assert property (
      (reg_req_in.wr && req_route && reg_req_in.addr[4:0] == 5'(gc / 2)
       && reg_req_in.wdata[4 * (gc % 2) +: 4] <= `PACM_CODE_Z_NEG)
      ##1 !reg_req_in.wr
      |-> ##1 $onehot(column_route_select_out[gc]))
      else $error("legal route code left its column without an output");

    a_col_code_dark: assert property (
      (reg_req_in.wr && req_route && reg_req_in.addr[4:0] == 5'(gc / 2)
       && reg_req_in.wdata[4 * (gc % 2) +: 4] > `PACM_CODE_Z_NEG)
      ##1 !reg_req_in.wr
      |-> ##1 column_route_select_out[gc] == '0)
      else $error("other route code did not shunt its column");
  end : g_col_chk

  c_pix_write: cover property (reg_req_in.wr && req_pix ##2 1'b1);
  c_route_write: cover property (reg_req_in.wr && req_route ##2 1'b1);
  c_read_hit: cover property (reg_req_in.rd && req_pix ##1 reg_resp_out.valid);
  c_read_miss: cover property (reg_req_in.rd && !req_pix && !req_route);
  c_route_read: cover property (reg_req_in.rd && req_route ##1 reg_resp_out.valid);

endmodule : pacm_top

/* pacm_host_model.sv */
`timescale 1ns/1ps
`include "pacm_consts.svh"

module pacm_host_model
  import pacm_pkg::*;
(
  input  wire logic       mclk_in,
  input  wire pacm_resp_t resp_in,
  output pacm_req_t       req_out
);
  initial req_out = '0;

  // released lines carry the inverse, so a stale address is never mistaken for a request
  task automatic wr_byte(input logic [15:0] addr, input logic [7:0] data);
    @(posedge mclk_in);
    req_out <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
    @(posedge mclk_in);
    req_out <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~data};
  endtask : wr_byte

  task automatic rd_byte(input logic [15:0] addr, output pacm_resp_t resp);
    @(posedge mclk_in);
    req_out <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'hA5};
    @(posedge mclk_in);
    req_out <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: 8'h5A};
    @(negedge mclk_in);
    resp = resp_in;
  endtask : rd_byte
endmodule : pacm_host_model

/* pacm_top_tb.sv */
`timescale 1ns/1ps
`include "pacm_consts.svh"

module pacm_top_tb
  import pacm_pkg::*;
;
  localparam logic [2:0]  GRP [8] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
  localparam logic [15:0] RDA [9] = '{16'h0000, 16'h0123, 16'h01FF, 16'h0400, 16'h041F,
                                      16'h0200, 16'h03FF, 16'h0420, 16'hFFFF};
  logic               mclk_in;
  logic               rstn_in;
  pacm_req_t          req;
  pacm_resp_t         resp;
  logic [63:0][63:0]  pix;
  pacm_route_t [63:0] route;
  logic [7:0]         mem [`PACM_MEM_BYTES];
  int                 error_cnt = 0;
  int                 check_count = 0;
  int                 cyc = 0;

  pacm_top pacm_top_i (.mclk_in(mclk_in), .rstn_in(rstn_in), .reg_req_in(req),
    .reg_resp_out(resp), .pixel_enable_bits_out(pix), .column_route_select_out(route));
  pacm_host_model pacm_host_model_i (.mclk_in(mclk_in), .resp_in(resp), .req_out(req));

  initial
  begin
    mclk_in = 1'b0;
    forever #50 mclk_in = ~mclk_in;
  end

  task automatic check(input string nm, input logic [4095:0] seen, input logic [4095:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : check

  function automatic logic mapped(input logic [15:0] a);
    return (a <= `PACM_PIX_LAST) || (a >= `PACM_ROUTE_FIRST && a <= `PACM_ROUTE_LAST);
  endfunction : mapped

  task automatic put(input logic [15:0] a, input logic [7:0] d);
    if (mapped(a))
      mem[(a < 16'h0200) ? int'(a) : int'(a) - 512] = d;
    pacm_host_model_i.wr_byte(a, d);
  endtask : put

  // outputs trail the storage write by one edge
  task automatic cmp_out;
    logic [63:0][63:0]  ep;
    pacm_route_t [63:0] er;
    logic [3:0]         c;
    @(posedge mclk_in);
    @(negedge mclk_in);
    for (int r = 0; r < 64; r++)
      for (int p = 0; p < 8; p++)
        for (int b = 0; b < 8; b++)
          ep[r][p * 8 + b] = mem[r * 8 + GRP[p]][b];
    for (int k = 0; k < 32; k++)
      for (int h = 0; h < 2; h++)
      begin
        c = mem[512 + k][h * 4 +: 4];
        er[2 * k + h] = (c < 4'h6) ? pacm_route_t'(6'h20 >> c) : '0;
      end
    check("pixels", 4096'(pix), 4096'(ep));
    check("routes", 4096'(route), 4096'(er));
  endtask : cmp_out

  task automatic t_reset;
    @(negedge mclk_in);
    check("rst_pixels", 4096'(pix), 4096'(0));
    check("rst_routes", 4096'(route), 4096'(0));
    check("rst_valid", 4096'(resp.valid), 4096'(0));
  endtask : t_reset

  task automatic t_load;
    for (int a = 0; a < 512; a++)
      put(16'(a), 8'(a ^ (a >> 3)));
    for (int k = 0; k < 32; k++)
      put(16'h0400 + 16'(k), {~4'(k), 4'(k)});
    cmp_out();
  endtask : t_load

  task automatic t_read;
    pacm_resp_t r;
    for (int i = 0; i < 9; i++)
    begin
      pacm_host_model_i.rd_byte(RDA[i], r);
      check("rd_valid", 4096'(r.valid), 4096'(1));
      check("rd_data", 4096'(r.data),
        4096'(mapped(RDA[i]) ? mem[(RDA[i] < 16'h0200) ? RDA[i] : RDA[i] - 512] : 8'h00));
    end
  endtask : t_read

  // aliases of mapped bytes must not reach storage
  task automatic t_unmapped;
    put(16'h0200, 8'hC3);
    put(16'h03FF, 8'hC3);
    put(16'h0420, 8'hC3);
    put(16'h0600, 8'hC3);
    put(16'hFC1F, 8'hC3);
    cmp_out();
  endtask : t_unmapped

  task automatic t_update;
    put(16'h041F, 8'h60);
    put(16'h01FF, 8'h00);
    put(16'h01FF, 8'h81);
    put(16'h0400, 8'hF5);
    cmp_out();
  endtask : t_update

  task automatic give_verdict;
    if (error_cnt == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  always @(posedge mclk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      give_verdict();
    end
  end

  initial
  begin
    rstn_in = 1'b0;
    repeat (12) @(posedge mclk_in);
    t_reset();
    @(posedge mclk_in);
    rstn_in <= 1'b1;
    t_load();
    t_read();
    t_unmapped();
    t_read();
    t_update();
    t_read();
    give_verdict();
  end
endmodule : pacm_top_tb
